// ### test/mic_core_model.sv
// Purpose: core sequencer and timer0 source model
// Assumes: one instruction per four clocks
// Notes: return pulse lags the bench command by one cycle
`timescale 1ns/1ps
module mic_core_model (
  input wire clk,
  input wire arst_n,
  input wire vector_load,
  input wire [12:0] vector_addr,
  input wire ret_cmd,
  input wire t0_run,
  output reg [12:0] program_counter,
  output reg return_from_interrupt,
  output reg [7:0] timer0_count
);
  reg [1:0] q_reg;
  // ==========================================
  // sequencer
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_reg <= 2'd0;
      program_counter <= 13'h0100;
      return_from_interrupt <= 1'b0;
      timer0_count <= 8'hF0;
    end else begin
      q_reg <= q_reg + 2'd1;
      if (vector_load) program_counter <= vector_addr;
      else if (q_reg == 2'd3) program_counter <= program_counter + 13'h0001;
      return_from_interrupt <= ret_cmd;
      // starts near the top so rollover comes quickly
      if (t0_run) timer0_count <= timer0_count + 8'h01;
    end
  end
endmodule // mic_core_model

// ### test/mic_irq_ctrl_asserts.sv
// Purpose: port checker for mic_irq_ctrl
// Assumes: one clock domain, async active-low reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
module mic_irq_ctrl_asserts (
  input wire clk,
  input wire arst_n,
  input wire irq_req,
  input wire vector_load,
  input wire [12:0] vector_addr,
  input wire stack_push,
  input wire sleeping,
  input wire wake_pulse
);
  // ==========================================
  // sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence vec_s;
    vector_load && stack_push && vector_addr == 13'h0004;
  endsequence
  sequence hold_s;
    !vector_load [*4];
  endsequence
  // ==========================================
  // properties
  AST_VECTOR: assert property (vector_load |-> vec_s) else $error("vector without push or address");
  AST_PULSE: assert property (vector_load |=> !vector_load && !stack_push) else $error("vector not a pulse");
  AST_GATED: assert property (vector_load |-> $past(irq_req)) else $error("vector without request");
  AST_DISARM: assert property (vector_load |-> ##[1:3] !irq_req) else $error("request kept after vector");
  AST_NOVEC_SLEEP: assert property (sleeping |-> !vector_load) else $error("vector while asleep");
  AST_WAKE: assert property (wake_pulse |-> $past(sleeping)) else $error("wake while running");
  AST_RESUME: assert property (wake_pulse |-> hold_s) else $error("vector too soon after wake");
  AST_RESET: assert property ($rose(arst_n) |-> !irq_req && !vector_load) else $error("request out of reset");
endmodule // mic_irq_ctrl_asserts

// ### test/mic_irq_ctrl_tb_top.sv
// Purpose: self-checking bench for mic_irq_ctrl
// Assumes: zero wait state slave, hready fed from hreadyout
// Notes: expectations come from the control bit layout
`timescale 1ns/1ps
`include "mic_regs.vh"
`define CHK(a, e) begin tests_run = tests_run + 1; if ((a) !== (e)) begin failures = failures + 1; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module mic_irq_ctrl_tb_top;
  reg clk = 0, arst_n = 0, hsel = 0, hwrite = 0, ext_irq_pin = 0, port_change_evt = 0, ret_cmd = 0, t0_run = 0;
  reg [11:0] haddr = 12'h000;
  reg [1:0] htrans = 2'b00;
  reg [31:0] hwdata = 32'h0000_0000;
  reg [7:0] periph_evt_a = 8'h00, periph_evt_b = 8'h00;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq_req, vector_load, stack_push, sleeping, wake_pulse, return_from_interrupt;
  wire [12:0] program_counter, vector_addr, push_addr;
  wire [7:0] timer0_count;
  integer failures = 0, tests_run = 0;
  reg hit;
  reg [12:0] pp;
  always #4 clk = ~clk;
  mic_irq_ctrl i_mic_irq_ctrl (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_irq_pin(ext_irq_pin), .port_change_evt(port_change_evt), .timer0_count(timer0_count),
    .periph_evt_a(periph_evt_a), .periph_evt_b(periph_evt_b), .program_counter(program_counter),
    .return_from_interrupt(return_from_interrupt), .irq_req(irq_req), .vector_load(vector_load),
    .vector_addr(vector_addr), .stack_push(stack_push), .push_addr(push_addr), .sleeping(sleeping),
    .wake_pulse(wake_pulse));
  mic_core_model i_mic_core_model (.clk(clk), .arst_n(arst_n), .vector_load(vector_load), .vector_addr(vector_addr),
    .ret_cmd(ret_cmd), .t0_run(t0_run), .program_counter(program_counter),
    .return_from_interrupt(return_from_interrupt), .timer0_count(timer0_count));
  // ==========================================
  // tasks
  task finish_test;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task ack;
    integer n;
    begin
      n = 0;
      do begin @(posedge clk); n = n + 1; end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin failures = failures + 1; finish_test; end
    end
  endtask
  task bus(input [11:0] a, input w, input [31:0] d, output [31:0] q);
    begin
      hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
      ack;
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      ack;
      q = hrdata;
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    reg [31:0] q;
    begin bus(a, 1'b1, {24'h00_0000, d}, q); end
  endtask
  task rd(input [11:0] a, input [7:0] e);
    reg [31:0] q;
    begin bus(a, 1'b0, 32'h0000_0000, q); `CHK(q, e) end
  endtask
  // bounded wait for a vector (sel 0) or a wake (sel 1); checks push_addr of the vector it waits for (sel 0 only)
  task wt(input integer lim, input sel);
    integer n;
    begin
      hit = 1'b0;
      for (n = 0; n < lim && !hit; n = n + 1) begin
        pp = program_counter;
        @(posedge clk);
        hit = sel ? (wake_pulse === 1'b1) : (vector_load === 1'b1);
        if (hit && !sel) `CHK(push_addr, pp)
      end
    end
  endtask
  task pin(input v);
    begin ext_irq_pin <= v; repeat (8) @(posedge clk); end
  endtask
  // ==========================================
  // scenarios
  task t_reset;
    begin
      rd(`MIC_OFS_CONTROL, 8'h00);
      rd(`MIC_OFS_STATUS, 8'h18);
      rd(`MIC_OFS_OPTION, 8'h01);
      rd(12'h0FC, 8'h00);
      `CHK(hresp, 1'b0)
      $display("t_reset done");
    end
  endtask
  task t_timer;
    begin
      t0_run <= 1'b1; repeat (20) @(posedge clk); t0_run <= 1'b0;
      rd(`MIC_OFS_CONTROL, 8'h04);
      wt(20, 1'b0); `CHK(hit, 1'b0)
      wr(`MIC_OFS_CONTROL, 8'hA4);
      wt(20, 1'b0); `CHK(hit, 1'b1)
      rd(`MIC_OFS_CONTROL, 8'h24);
      wr(`MIC_OFS_CONTROL, 8'h20);
      ret_cmd <= 1'b1; @(posedge clk); ret_cmd <= 1'b0; @(posedge clk);
      rd(`MIC_OFS_CONTROL, 8'hA0);
      $display("t_timer done");
    end
  endtask
  task t_pin;
    begin
      wr(`MIC_OFS_CONTROL, 8'h80); pin(1'b1);
      rd(`MIC_OFS_CONTROL, 8'h82);
      wt(20, 1'b0); `CHK(hit, 1'b0)
      wr(`MIC_OFS_CONTROL, 8'h90); wr(`MIC_OFS_OPTION, 8'h00);
      ext_irq_pin <= 1'b0; wt(17, 1'b0); `CHK(hit, 1'b1)
      rd(`MIC_OFS_CONTROL, 8'h12);
      wr(`MIC_OFS_CONTROL, 8'h10); pin(1'b1);
      rd(`MIC_OFS_CONTROL, 8'h10);
      wr(`MIC_OFS_OPTION, 8'h03); pin(1'b0); pin(1'b1);
      rd(`MIC_OFS_CONTROL, 8'h10);
      $display("t_pin done");
    end
  endtask
  task t_pending;
    begin
      wr(`MIC_OFS_OPTION, 8'h01); wr(`MIC_OFS_CONTROL, 8'h90); wr(`MIC_OFS_CORE, 8'h04);
      pin(1'b0); pin(1'b1);
      wt(20, 1'b0); `CHK(hit, 1'b0)
      rd(`MIC_OFS_CONTROL, 8'h12);
      wr(`MIC_OFS_CONTROL, 8'h92); wt(20, 1'b0); `CHK(hit, 1'b1)
      $display("t_pending done");
    end
  endtask
  task t_sleep;
    begin
      wr(`MIC_OFS_CONTROL, 8'h10); pin(1'b0); wr(`MIC_OFS_CORE, 8'h02); @(posedge clk);
      `CHK(sleeping, 1'b1)
      wr(`MIC_OFS_STATUS, 8'h0C);
      wr(`MIC_OFS_CONTROL, 8'h90); ext_irq_pin <= 1'b1;
      wt(20, 1'b1); `CHK(hit, 1'b1)
      wt(30, 1'b0); `CHK(hit, 1'b1)
      rd(`MIC_OFS_STATUS, 8'h14);
      $display("t_sleep done");
    end
  endtask
  task t_periph;
    begin
      wr(`MIC_OFS_CONTROL, 8'h00); wr(`MIC_OFS_PEN_A, 8'h01); wr(`MIC_OFS_CONTROL, 8'hC0);
      periph_evt_a <= 8'h01; @(posedge clk); periph_evt_a <= 8'h00;
      wt(20, 1'b0); `CHK(hit, 1'b1)
      rd(`MIC_OFS_PREQ_A, 8'h01);
      periph_evt_b <= 8'hFF; port_change_evt <= 1'b1; @(posedge clk);
      periph_evt_b <= 8'h00; port_change_evt <= 1'b0;
      rd(`MIC_OFS_PREQ_B, 8'hF5);
      rd(`MIC_OFS_CONTROL, 8'h41);
      $display("t_periph done");
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset; t_timer; t_pin; t_pending; t_sleep; t_periph;
    finish_test;
  end
endmodule // mic_irq_ctrl_tb_top
bind mic_irq_ctrl mic_irq_ctrl_asserts i_mic_irq_ctrl_asserts (.clk(clk), .arst_n(arst_n), .irq_req(irq_req),
  .vector_load(vector_load), .vector_addr(vector_addr), .stack_push(stack_push), .sleeping(sleeping),
  .wake_pulse(wake_pulse));

// ### verilog/mic_edge_sync.v
// Purpose: two-flop synchroniser with edge select for the external pin
// Assumes: pin asynchronous to clk
// Notes: first flop read only by second flop
`timescale 1ns/1ps
module mic_edge_sync (
  input wire clk,
  input wire arst_n,
  input wire pin_in,
  input wire rising_sel,
  output reg edge_pulse
);
  reg meta_reg;
  reg sync_reg;
  reg prev_reg;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      // rising when select set, falling when clear
      edge_pulse <= rising_sel ? (sync_reg & ~prev_reg) : (~sync_reg & prev_reg);
    end
  end
endmodule // mic_edge_sync

// ### verilog/mic_irq_ctrl.v
// Contract
// - global enable gates every unmasked source
// - any reset clears global enable
// - return instruction sets global enable again
// - service clears enable, pushes, vectors 0004h
// - external event latency three or four cycles
// - flags set regardless of any enable
// - disabled pending requests wait for re-enable
// - each source masked by own enable
// - flags live in control and request registers
// - pin edge chosen by edge select
// - valid pin edge sets pin flag
// - pin enable clear blocks pin interrupt
// - enabled pin event wakes core from sleep
// - after wake, next instruction runs before vector
// - wake sets time-out, clears power-down bit
// - timer0 rollover sets overflow flag
// - lcd segment function disables pin interrupt
//
// Purpose: interrupt flag/enable registers, vectoring and wake control
// Assumes: core runs one instruction cycle per four clocks (tcy_strobe)
// Notes: AHB-Lite slave, zero wait states, always OKAY
`timescale 1ns/1ps
`include "mic_regs.vh"
module mic_irq_ctrl (
  input wire clk,
  input wire arst_n,
  // ahb-lite
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // event sources
  input wire ext_irq_pin,
  input wire port_change_evt,
  input wire [7:0] timer0_count,
  input wire [7:0] periph_evt_a,
  input wire [7:0] periph_evt_b,
  // core side
  input wire [12:0] program_counter,
  input wire return_from_interrupt,
  output reg irq_req,
  output reg vector_load,
  output reg [12:0] vector_addr,
  output reg stack_push,
  output reg [12:0] push_addr,
  output reg sleeping,
  output reg wake_pulse
);
  // ==========================================
  // state
  localparam [2:0] ST_RUN = 3'b001;
  localparam [2:0] ST_SLEEP = 3'b010;
  localparam [2:0] ST_WAKE = 3'b100;
  localparam integer TCY_CLKS = `MIC_TCY_NS / `MIC_CLK_NS;

  reg [2:0] state_reg;
  reg [1:0] tcy_cnt_reg;
  reg [7:0] control_reg;
  reg [7:0] preq_a_reg;
  reg [7:0] preq_b_reg;
  reg [7:0] pen_a_reg;
  reg [7:0] pen_b_reg;
  reg [1:0] option_reg;
  reg [7:0] status_reg;
  reg [7:0] tmr_prev_reg;
  reg [1:0] pend_pipe_reg;
  reg hold_reg;
  reg wr_pend_reg;
  reg [11:0] wr_addr_reg;
  wire ext_edge;
  wire tcy_strobe;
  wire [7:0] control_next;
  wire tmr_roll;
  wire req_any;
  wire req_raw;
  wire ap_valid;
  wire [7:0] wdat;
  wire core_ret;
  wire core_sleep;
  wire core_genclr;

  function sel;
    input [11:0] a;
    input [11:0] ofs;
    begin
      sel = (a[11:2] == ofs[11:2]);
    end
  endfunction

  // ==========================================
  // external pin path
  mic_edge_sync u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pin_in(ext_irq_pin),
    .rising_sel(option_reg[`MIC_OPT_EDGE]),
    .edge_pulse(ext_edge)
  );

  assign tcy_strobe = (tcy_cnt_reg == TCY_CLKS[1:0] - 2'd1);
  assign tmr_roll = (tmr_prev_reg == 8'hFF) && (timer0_count == 8'h00);
  assign ap_valid = hsel & hready & htrans[1];
  assign wdat = hwdata[7:0];
  assign core_ret = wr_pend_reg & sel(wr_addr_reg, `MIC_OFS_CORE) & wdat[`MIC_CORE_RET];
  assign core_sleep = wr_pend_reg & sel(wr_addr_reg, `MIC_OFS_CORE) & wdat[`MIC_CORE_SLEEP];
  assign core_genclr = wr_pend_reg & sel(wr_addr_reg, `MIC_OFS_CORE) & wdat[`MIC_CORE_GENCLR];

  // masked requests without the global enable
  assign req_raw = (control_reg[`MIC_CTL_T0EN] & control_reg[`MIC_CTL_T0FLG]) |
                   (control_reg[`MIC_CTL_EXTIE] & control_reg[`MIC_CTL_EXTIF]) |
                   (control_reg[`MIC_CTL_PCIE] & control_reg[`MIC_CTL_PCIF]) |
                   (control_reg[`MIC_CTL_PEIE] &
                    (|(preq_a_reg & pen_a_reg) | |(preq_b_reg & pen_b_reg)));
  assign req_any = control_reg[`MIC_CTL_GEN] & req_raw;

  // ==========================================
  // control register next value; hardware set beats software clear
  wire ctl_wr;
  wire take;
  assign ctl_wr = wr_pend_reg & sel(wr_addr_reg, `MIC_OFS_CONTROL);
  // vector taken at tcy boundary once pipeline has matured, global enable still set
  assign take = tcy_strobe & pend_pipe_reg[1] & req_any & (state_reg == ST_RUN) & ~core_genclr;
  wire [7:0] ctl_base;
  assign ctl_base = ctl_wr ? wdat : control_reg;
  wire gen_next;
  assign gen_next = take ? 1'b0 :
                    (core_ret | return_from_interrupt) ? 1'b1 :
                    core_genclr ? 1'b0 : ctl_base[`MIC_CTL_GEN];
  assign control_next = {gen_next, ctl_base[6:3],
                         ctl_base[`MIC_CTL_T0FLG] | tmr_roll,
                         ctl_base[`MIC_CTL_EXTIF] | (ext_edge & ~option_reg[`MIC_OPT_LCDSEG]),
                         ctl_base[`MIC_CTL_PCIF] | port_change_evt};

  // ==========================================
  // registers
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      control_reg <= `MIC_RST_CONTROL;
      preq_a_reg <= 8'h00;
      preq_b_reg <= 8'h00;
      pen_a_reg <= 8'h00;
      pen_b_reg <= 8'h00;
      option_reg <= 2'b01;
      status_reg <= `MIC_RST_STATUS;
      tmr_prev_reg <= 8'h00;
      tcy_cnt_reg <= 2'd0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else begin
      tcy_cnt_reg <= tcy_cnt_reg + 2'd1;
      tmr_prev_reg <= timer0_count;
      wr_pend_reg <= ap_valid & hwrite;
      if (ap_valid) begin
        wr_addr_reg <= haddr;
      end
      control_reg <= control_next;
      preq_a_reg <= ((wr_pend_reg && sel(wr_addr_reg, `MIC_OFS_PREQ_A)) ? wdat : preq_a_reg) | periph_evt_a;
      preq_b_reg <= (((wr_pend_reg && sel(wr_addr_reg, `MIC_OFS_PREQ_B)) ? wdat : preq_b_reg) | periph_evt_b)
                    & `MIC_PREQ_B_MASK;
      if (wr_pend_reg && sel(wr_addr_reg, `MIC_OFS_PEN_A)) begin
        pen_a_reg <= wdat;
      end
      if (wr_pend_reg && sel(wr_addr_reg, `MIC_OFS_PEN_B)) begin
        pen_b_reg <= wdat & `MIC_PREQ_B_MASK;
      end
      if (wr_pend_reg && sel(wr_addr_reg, `MIC_OFS_OPTION)) begin
        option_reg <= wdat[1:0];
      end
      if (state_reg == ST_SLEEP && (req_raw || (control_reg[`MIC_CTL_EXTIE] && control_reg[`MIC_CTL_EXTIF]))) begin
        status_reg[`MIC_ST_TO] <= 1'b1;
        status_reg[`MIC_ST_PD] <= 1'b0;
      end else if (core_sleep) begin
        status_reg[`MIC_ST_PD] <= 1'b0;
        status_reg[`MIC_ST_TO] <= 1'b1;
      end else if (wr_pend_reg && sel(wr_addr_reg, `MIC_OFS_STATUS)) begin
        status_reg <= wdat;
      end
    end
  end

  // ==========================================
  // sequencer: latency pipeline, sleep and wake
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_RUN;
      pend_pipe_reg <= 2'b00;
      hold_reg <= 1'b0;
      irq_req <= 1'b0;
      vector_load <= 1'b0;
      vector_addr <= 13'h0000;
      stack_push <= 1'b0;
      push_addr <= 13'h0000;
      sleeping <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      irq_req <= req_any;
      vector_load <= take;
      stack_push <= take;
      wake_pulse <= 1'b0;
      if (take) begin
        vector_addr <= `MIC_VECTOR;
        push_addr <= program_counter;
      end
      // request must persist three tcy boundaries: 2-3 tcy to vector
      if (tcy_strobe) begin
        pend_pipe_reg <= req_any ? {pend_pipe_reg[0], 1'b1} : 2'b00;
      end
      case (state_reg)
        ST_RUN: begin
          if (core_sleep) begin
            state_reg <= ST_SLEEP;
            sleeping <= 1'b1;
          end
        end
        ST_SLEEP: begin
          // enable must have been set already; global enable not needed to wake
          if (req_raw) begin
            state_reg <= ST_WAKE;
            sleeping <= 1'b0;
            wake_pulse <= 1'b1;
            hold_reg <= 1'b1;
            pend_pipe_reg <= 2'b00;
          end
        end
        ST_WAKE: begin
          // one full tcy for the instruction after sleep
          if (tcy_strobe) begin
            hold_reg <= 1'b0;
            if (!hold_reg) begin
              state_reg <= ST_RUN;
            end
          end
        end
        default: begin
          state_reg <= ST_RUN;
        end
      endcase
    end
  end

  // ==========================================
  // ahb-lite data phase: zero wait, okay
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ap_valid && !hwrite) begin
        if (sel(haddr, `MIC_OFS_CONTROL)) begin
          hrdata <= {24'h00_0000, control_next};
        end else if (sel(haddr, `MIC_OFS_PREQ_A)) begin
          hrdata <= {24'h00_0000, preq_a_reg};
        end else if (sel(haddr, `MIC_OFS_PREQ_B)) begin
          hrdata <= {24'h00_0000, preq_b_reg};
        end else if (sel(haddr, `MIC_OFS_PEN_A)) begin
          hrdata <= {24'h00_0000, pen_a_reg};
        end else if (sel(haddr, `MIC_OFS_PEN_B)) begin
          hrdata <= {24'h00_0000, pen_b_reg};
        end else if (sel(haddr, `MIC_OFS_OPTION)) begin
          hrdata <= {30'h0000_0000, option_reg};
        end else if (sel(haddr, `MIC_OFS_STATUS)) begin
          hrdata <= {24'h00_0000, status_reg};
        end else if (sel(haddr, `MIC_OFS_CORE)) begin
          hrdata <= {29'h0000_0000, state_reg};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end
endmodule // mic_irq_ctrl

// ### verilog/mic_regs.vh
// Purpose: constants for the interrupt control block
// Assumes: AHB-Lite word registers, 125 MHz clock
// Notes: offsets are byte addresses
`ifndef MIC_REGS_VH
`define MIC_REGS_VH
// ==========================================
// register offsets
`define MIC_OFS_CONTROL 12'h000
`define MIC_OFS_PREQ_A 12'h004
`define MIC_OFS_PREQ_B 12'h008
`define MIC_OFS_PEN_A 12'h00C
`define MIC_OFS_PEN_B 12'h010
`define MIC_OFS_OPTION 12'h014
`define MIC_OFS_STATUS 12'h018
`define MIC_OFS_CORE 12'h01C
// ==========================================
// control register fields
`define MIC_CTL_GEN 7
`define MIC_CTL_PEIE 6
`define MIC_CTL_T0EN 5
`define MIC_CTL_EXTIE 4
`define MIC_CTL_PCIE 3
`define MIC_CTL_T0FLG 2
`define MIC_CTL_EXTIF 1
`define MIC_CTL_PCIF 0
// option and status fields
`define MIC_OPT_EDGE 0
`define MIC_OPT_LCDSEG 1
`define MIC_ST_TO 4
`define MIC_ST_PD 3
// core register fields (write: bit0 return, bit1 sleep, bit2 clear global enable)
`define MIC_CORE_RET 0
`define MIC_CORE_SLEEP 1
`define MIC_CORE_GENCLR 2
// ==========================================
// reset values and masks
`define MIC_RST_CONTROL 8'h00
`define MIC_RST_STATUS 8'h18
`define MIC_PREQ_B_MASK 8'hF5
`define MIC_VECTOR 13'h0004
`define MIC_TCY_NS 32
`define MIC_CLK_NS 8
`define MIC_TCY_CYC 4
`endif
